// [src/rscr_pkg.sv]
// Shared constants for the radio status and configuration register bank.
// Assumes a 125 MHz system clock and register offsets on an 11-bit index.
package rscr_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 11;
  localparam logic [10:0] OFS_CONV_RB_HIGH = 11'h327;
  localparam logic [10:0] OFS_CONV_RB_LOW  = 11'h328;
  localparam logic [10:0] OFS_GAIN_DIV     = 11'h32f;
  localparam logic [10:0] OFS_EV_RADIO     = 11'h336;
  localparam logic [10:0] OFS_EV_SYSTEM    = 11'h337;
  localparam logic [10:0] OFS_CAL_EN       = 11'h338;
  localparam logic [10:0] OFS_CAL_DONE     = 11'h339;
  localparam logic [10:0] OFS_CAL_WORD_RB  = 11'h345;
  localparam logic [10:0] OFS_CAL_WORD_OVR = 11'h346;
  localparam logic [10:0] OFS_CONV_LOW     = 11'h359;
  localparam logic [10:0] OFS_CONV_HIGH    = 11'h35a;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_GAIN_DIV  = 8'h28;
  localparam logic [6:0] RST_CONV_HIGH = 7'h1f;
  localparam logic [7:0] EV_SYSTEM_USE = 8'hd3;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int EV_WAKE_COUNT = 7;
  localparam int EV_SIG_DETECT = 6;
  localparam int EV_CIPHER     = 5;
  localparam int EV_TX_DONE    = 4;
  localparam int EV_ADDR_MATCH = 3;
  localparam int EV_CRC_GOOD   = 2;
  localparam int EV_SYNC       = 1;
  localparam int EV_PREAMBLE   = 0;
  localparam int EV_BATTERY    = 7;
  localparam int EV_CMD_READY  = 6;
  localparam int EV_WAKE_TIMER = 4;
  localparam int EV_PORT_READY = 1;
  localparam int EV_CMD_DONE   = 0;
  localparam int CAL_SYNTH     = 1;
  localparam int CAL_FILTER    = 0;

  // ----------------------------------------------------------------
  // Rates and converter modes
  // ----------------------------------------------------------------
  localparam logic [7:0] REF_MHZ    = 8'h1a;
  localparam logic [7:0] CLK_MHZ    = 8'h7d;
  localparam int         RATE_SHIFT = 4;
  localparam int         FILT_SHIFT = 2;
  localparam logic [1:0] MODE_RAW      = 2'h0;
  localparam logic [1:0] MODE_ON_READ  = 2'h1;
  localparam logic [1:0] MODE_ON_RATE  = 2'h2;
  localparam logic [1:0] MODE_LOOP_FLT = 2'h3;

endpackage

// [src/rscr_aux_if.sv]
// Carrier between the register bank, the gain-rate divider and the converter filter.
// Assumes all three share clk.
`timescale 1ns/1ps
interface rscr_aux_if;
  logic [7:0] divider;
  logic       gain_tick;
  logic [1:0] mode;
  logic       sample_valid;
  logic [7:0] sample;
  logic       rb_read;
  logic [7:0] readback;
  logic [7:0] loop_sample;

  modport regs (output divider, output mode, output sample_valid, output sample,
                output rb_read, input gain_tick, input readback, input loop_sample);
  modport rate (input divider, output gain_tick);
  modport filt (input gain_tick, input mode, input sample_valid, input sample,
                input rb_read, output readback, output loop_sample);
endinterface

// [src/rscr_rate_div.sv]
// Gain-control update rate divider: 26 MHz reference ticks made from clk by a
// fractional accumulator, then divided by 16 times the divider field.
// Assumes clk at 125 MHz.
`timescale 1ns/1ps
module rscr_rate_div
  import rscr_pkg::*;
(
  input  wire logic clk,
  input  wire logic srst,
  rscr_aux_if.rate  aux
);

  typedef struct packed {
    logic [7:0]  acc;
    logic [11:0] ref_cnt;
    logic        tick;
  } rscr_div_t;

  rscr_div_t st;
  rscr_div_t next_st;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [8:0]  sum;
    logic [11:0] limit;
    sum = 9'(st.acc) + 9'(REF_MHZ);
    limit = 12'(aux.divider) << RATE_SHIFT;
    next_st = st;
    next_st.tick = 1'b0;
    if (sum >= 9'(CLK_MHZ))
    begin
      next_st.acc = 8'(sum - 9'(CLK_MHZ));
      // Divider of zero stops the rate rather than wrapping
      if (limit != 12'h000 && st.ref_cnt + 12'h001 >= limit)
      begin
        next_st.ref_cnt = 12'h000;
        next_st.tick = 1'b1;
      end
      else
        next_st.ref_cnt = st.ref_cnt + 12'h001;
    end
    else
      next_st.acc = sum[7:0];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      st <= '0;
    else
      st <= next_st;
  end

  assign aux.gain_tick = st.tick;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  rate_spacing_a: assert property (st.tick |=> !st.tick [*8])
    else $error("gain rate ticks too close");

endmodule

// [src/rscr_conv_filt.sv]
// Converter result filtering and readback selection.
// Assumes samples arrive as one-cycle valid pulses on clk.
`timescale 1ns/1ps
module rscr_conv_filt
  import rscr_pkg::*;
(
  input  wire logic clk,
  input  wire logic srst,
  rscr_aux_if.filt  aux
);

  typedef struct packed {
    logic [7:0] raw;
    logic [7:0] avg;
    logic [7:0] snap;
    logic [7:0] loop_v;
  } rscr_filt_t;

  rscr_filt_t st;
  rscr_filt_t next_st;

  // ----------------------------------------------------------------
  // Filter and readback
  // ----------------------------------------------------------------
  always_comb
  begin
    logic signed [8:0] diff;
    diff = $signed({1'b0, aux.sample}) - $signed({1'b0, st.avg});
    next_st = st;
    if (aux.sample_valid)
    begin
      next_st.raw = aux.sample;
      // Short first-order average; cheap and needs no multiplier
      next_st.avg = 8'(st.avg + 8'(diff >>> FILT_SHIFT));
    end
    case (aux.mode)
      MODE_RAW:      next_st.snap = next_st.raw;
      MODE_ON_READ:  if (aux.rb_read) next_st.snap = st.avg;
      MODE_ON_RATE:  if (aux.gain_tick) next_st.snap = st.avg;
      MODE_LOOP_FLT: if (aux.gain_tick) next_st.snap = st.avg;
      default:       next_st.snap = st.snap;
    endcase
    next_st.loop_v = (aux.mode == MODE_LOOP_FLT) ? st.avg : st.raw;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      st <= '0;
    else
      st <= next_st;
  end

  assign aux.readback    = st.snap;
  assign aux.loop_sample = st.loop_v;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  loop_select_a: assert property (aux.mode == MODE_RAW && $stable(aux.mode) |=>
                                  st.loop_v == $past(st.raw))
    else $error("gain loop not fed raw in plain mode");

endmodule

// [src/rscr_regs.sv]
// Register bank for radio status, event flags, calibration and converter setup.
// Assumes a register port from the serial control logic on clk, one access per cycle,
// and event inputs as one-cycle pulses from logic on the same clock.
`timescale 1ns/1ps

// Function
// - Gain rate is 26 MHz over sixteen times divider; divider resets to 40.
// - Radio flag 7 sets when wake-up count reaches its limit.
// - Radio flag 6 sets when low-power signal level exceeds threshold.
// - Radio flag 5 sets on cipher completion, only with cipher module loaded.
// - Radio flag 4 sets on transmit end, packet mode only.
// - Radio flag 3 sets on address match, packet mode only.
// - Radio flag 2 sets on good checksum, packet mode only.
// - Radio flag 1 sets on qualified sync word.
// - Radio flag 0 sets on qualified preamble.
// - System flag 7 sets when supply falls below battery threshold.
// - System flag 6 sets when command processor is ready.
// - System flag 4 sets on wake timer expiry; bits 5, 3, 2 unused.
// - System flag 1 on control port ready, flag 0 on command done.
// - Calibration enables: bit 1 synthesizer, bit 0 filter; reset zero.
// - Done bit 1 reads synthesizer calibration finished.
// - Done bit 0 reads filter calibration complete, meaningful while enabled.
// - Six-bit filter calibration word readable after calibration completes.
// - Override register: word in bits 6..1, enable bit 0, reset zero.
// - Two-bit converter reference select, code 0 default.
// - Two-bit converter filtering mode chooses loop and readback filtering.
// - Converter reference enable resets to 1; 0 powers reference down.
// - Converter result split: six MSBs high register, two LSBs low register.
module rscr_regs
  import rscr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [10:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        wake_event,
  input  wire logic [15:0] wake_count_limit,
  input  wire logic        lowpower_mode,
  input  wire logic        signal_valid,
  input  wire logic [7:0]  signal_level,
  input  wire logic [7:0]  lowpower_signal_threshold,
  input  wire logic        cipher_loaded,
  input  wire logic        cipher_done,
  input  wire logic        packet_mode,
  input  wire logic        tx_done,
  input  wire logic        addr_match,
  input  wire logic        crc_good,
  input  wire logic        sync_found,
  input  wire logic        preamble_found,
  input  wire logic        supply_low,
  input  wire logic        cmd_ready,
  input  wire logic        wake_timer_expired,
  input  wire logic        port_ready,
  input  wire logic        cmd_done,
  input  wire logic        synth_calibrate_done,
  input  wire logic        filter_calibrate_done,
  input  wire logic        power_ramp_done,
  input  wire logic [5:0]  filter_cal_word_in,
  input  wire logic        conv_valid,
  input  wire logic [7:0]  conv_sample,
  output logic             synth_calibrate_enable,
  output logic             filter_calibrate_enable,
  output logic      [5:0]  filter_cal_word,
  output logic      [1:0]  converter_channel_select,
  output logic      [1:0]  converter_reference_select,
  output logic             converter_reference_enable,
  output logic             gain_tick,
  output logic      [7:0]  gain_loop_sample,
  output logic      [15:0] wake_counter
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  div;
    logic [7:0]  ev_radio;
    logic [7:0]  ev_system;
    logic [1:0]  cal_en;
    logic [5:0]  cal_word;
    logic        filt_done_q;
    logic [6:0]  ovr;
    logic [3:0]  conv_low;
    logic [6:0]  conv_high;
    logic [15:0] wake_cnt;
    logic [7:0]  rdata;
  } rscr_state_t;

  rscr_state_t st;
  rscr_state_t next_st;
  logic [7:0]  set_radio;
  logic [7:0]  set_system;
  logic        wr_radio;
  logic        wr_system;

  rscr_aux_if aux ();

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  rscr_rate_div rscr_rate_div_i
  (
    .clk  (clk),
    .srst (srst),
    .aux  (aux.rate)
  );

  rscr_conv_filt rscr_conv_filt_i
  (
    .clk  (clk),
    .srst (srst),
    .aux  (aux.filt)
  );

  assign aux.divider      = st.div;
  assign aux.mode         = st.conv_high[6:5];
  assign aux.sample_valid = conv_valid;
  assign aux.sample       = conv_sample;
  assign aux.rb_read      = reg_rd && reg_addr == OFS_CONV_RB_HIGH;

  assign wr_radio  = reg_wr && reg_addr == OFS_EV_RADIO;
  assign wr_system = reg_wr && reg_addr == OFS_EV_SYSTEM;

  // ----------------------------------------------------------------
  // Event sources
  // ----------------------------------------------------------------
  always_comb
  begin
    set_radio = 8'h00;
    set_radio[EV_WAKE_COUNT] = wake_event &&
                               (st.wake_cnt + 16'h0001) == wake_count_limit;
    set_radio[EV_SIG_DETECT] = lowpower_mode && signal_valid &&
                               signal_level > lowpower_signal_threshold;
    set_radio[EV_CIPHER]     = cipher_done && cipher_loaded;
    set_radio[EV_TX_DONE]    = tx_done && packet_mode;
    set_radio[EV_ADDR_MATCH] = addr_match && packet_mode;
    set_radio[EV_CRC_GOOD]   = crc_good && packet_mode;
    set_radio[EV_SYNC]       = sync_found;
    set_radio[EV_PREAMBLE]   = preamble_found;
  end

  always_comb
  begin
    set_system = 8'h00;
    set_system[EV_BATTERY]    = supply_low;
    set_system[EV_CMD_READY]  = cmd_ready;
    set_system[EV_WAKE_TIMER] = wake_timer_expired;
    set_system[EV_PORT_READY] = port_ready;
    set_system[EV_CMD_DONE]   = cmd_done;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;

    if (wake_event)
      next_st.wake_cnt = st.wake_cnt + 16'h0001;

    // A write replaces the flags, but a set in the same cycle still wins
    if (wr_radio)
      next_st.ev_radio = reg_wdata | set_radio;
    else
      next_st.ev_radio = st.ev_radio | set_radio;
    if (wr_system)
      next_st.ev_system = (reg_wdata | set_system) & EV_SYSTEM_USE;
    else
      next_st.ev_system = st.ev_system | set_system;

    // Word is captured on the rising completion, so readback stays stable
    next_st.filt_done_q = filter_calibrate_done;
    if (filter_calibrate_done && !st.filt_done_q && st.cal_en[CAL_FILTER])
      next_st.cal_word = filter_cal_word_in;

    if (reg_wr)
    begin
      case (reg_addr)
        OFS_GAIN_DIV:     next_st.div = reg_wdata;
        OFS_CAL_EN:       next_st.cal_en = reg_wdata[1:0];
        OFS_CAL_WORD_OVR: next_st.ovr = reg_wdata[6:0];
        OFS_CONV_LOW:     next_st.conv_low = reg_wdata[3:0];
        OFS_CONV_HIGH:    next_st.conv_high = reg_wdata[6:0];
        default:          next_st.div = st.div;
      endcase
    end

    if (reg_rd)
    begin
      case (reg_addr)
        OFS_CONV_RB_HIGH: next_st.rdata = {2'h0, aux.readback[7:2]};
        OFS_CONV_RB_LOW:  next_st.rdata = {aux.readback[1:0], 6'h00};
        OFS_GAIN_DIV:     next_st.rdata = st.div;
        OFS_EV_RADIO:     next_st.rdata = st.ev_radio;
        OFS_EV_SYSTEM:    next_st.rdata = st.ev_system;
        OFS_CAL_EN:       next_st.rdata = {6'h00, st.cal_en};
        OFS_CAL_DONE:     next_st.rdata = {5'h00, power_ramp_done,
                                           synth_calibrate_done,
                                           filter_calibrate_done &&
                                           st.cal_en[CAL_FILTER]};
        OFS_CAL_WORD_RB:  next_st.rdata = {2'h0, st.cal_word};
        OFS_CAL_WORD_OVR: next_st.rdata = {1'b0, st.ovr};
        OFS_CONV_LOW:     next_st.rdata = {4'h0, st.conv_low};
        OFS_CONV_HIGH:    next_st.rdata = {1'b0, st.conv_high};
        default:          next_st.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st <= '0;
      st.div <= RST_GAIN_DIV;
      st.conv_high <= RST_CONV_HIGH;
    end
    else
      st <= next_st;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata                  = st.rdata;
  assign synth_calibrate_enable     = st.cal_en[CAL_SYNTH];
  assign filter_calibrate_enable    = st.cal_en[CAL_FILTER];
  assign filter_cal_word            = st.ovr[0] ? st.ovr[6:1] : st.cal_word;
  assign converter_channel_select   = st.conv_low[3:2];
  assign converter_reference_select = st.conv_low[1:0];
  assign converter_reference_enable = st.conv_high[4];
  assign gain_tick                  = aux.gain_tick;
  assign gain_loop_sample           = aux.loop_sample;
  assign wake_counter               = st.wake_cnt;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence status_read_idle_s;
    reg_rd && reg_addr == OFS_CAL_DONE && !st.cal_en[CAL_FILTER];
  endsequence

  sequence en_read_s;
    reg_rd && reg_addr == OFS_CAL_EN;
  endsequence

  sequence filt_rise_s;
    filter_calibrate_done && !$past(filter_calibrate_done) && filter_calibrate_enable;
  endsequence

  tx_flag_set_a: assert property (packet_mode && tx_done |=> st.ev_radio[EV_TX_DONE])
    else $error("transmit flag not set");

  tx_flag_gate_a: assert property (!packet_mode && !wr_radio &&
                                   !st.ev_radio[EV_TX_DONE] |=> !st.ev_radio[EV_TX_DONE])
    else $error("transmit flag set outside packet mode");

  cipher_gate_a: assert property (!cipher_loaded && !wr_radio &&
                                  !st.ev_radio[EV_CIPHER] |=> !st.ev_radio[EV_CIPHER])
    else $error("cipher flag without module");

  cipher_set_a: assert property (cipher_loaded && cipher_done
                                 |=> st.ev_radio[EV_CIPHER])
    else $error("cipher flag missed");

  rx_flags_set_a: assert property ((packet_mode && addr_match
                                    |=> st.ev_radio[EV_ADDR_MATCH]) and
                                   (packet_mode && crc_good |=> st.ev_radio[EV_CRC_GOOD]))
    else $error("receive flag missed");

  detect_flags_a: assert property ((sync_found |=> st.ev_radio[EV_SYNC]) and
                                   (preamble_found |=> st.ev_radio[EV_PREAMBLE]))
    else $error("detect flag missed");

  signal_flag_a: assert property (lowpower_mode && signal_valid &&
                                  signal_level > lowpower_signal_threshold
                                  |=> st.ev_radio[EV_SIG_DETECT])
    else $error("signal detect flag missed");

  wake_limit_a: assert property (wake_event &&
                                 st.wake_cnt + 16'h0001 == wake_count_limit
                                 |=> st.ev_radio[EV_WAKE_COUNT] &&
                                     wake_counter == $past(wake_count_limit))
    else $error("wake count flag missed");

  battery_set_a: assert property (supply_low
                                  |=> st.ev_system[EV_BATTERY])
    else $error("battery flag missed");

  system_flags_a: assert property ((cmd_ready
                                    |=> st.ev_system[EV_CMD_READY]) and
                                   (wake_timer_expired |=> st.ev_system[EV_WAKE_TIMER]))
    else $error("system flag missed");

  unused_bits_a: assert property ((st.ev_system & ~EV_SYSTEM_USE) == 8'h00)
    else $error("unused system flag set");

  port_done_set_a: assert property ((port_ready
                                     |=> st.ev_system[EV_PORT_READY]) and
                                    (cmd_done |=> st.ev_system[EV_CMD_DONE]))
    else $error("port or command flag missed");

  flag_hold_a: assert property (st.ev_system[EV_BATTERY] && !wr_system
                                |=> st.ev_system[EV_BATTERY] [*1])
    else $error("battery flag dropped without write");

  ovr_select_a: assert property (reg_wr && reg_wdata[0] &&
                                 reg_addr == OFS_CAL_WORD_OVR
                                 |=> {1'b0, filter_cal_word, 1'b1} == ($past(reg_wdata) & 8'h7f))
    else $error("override word not applied");

  word_capture_a: assert property (filt_rise_s
                                   |=> st.cal_word == $past(filter_cal_word_in))
    else $error("calibration word not captured");

  synth_read_a: assert property (reg_rd && reg_addr == OFS_CAL_DONE
                                 |=> reg_rdata[CAL_SYNTH] == $past(synth_calibrate_done))
    else $error("synthesizer done readback wrong");

  filter_idle_a: assert property (status_read_idle_s |=> !reg_rdata[0])
    else $error("filter done read while disabled");

  en_readback_a: assert property (en_read_s and !reg_wr
                                  |=> reg_rdata == {6'h00, $past(st.cal_en)})
    else $error("calibration enable readback wrong");

  div_write_a: assert property (reg_wr && reg_addr == OFS_GAIN_DIV
                                |=> st.div == $past(reg_wdata))
    else $error("divider write lost");

  split_read_a: assert property (reg_rd && reg_addr == OFS_CONV_RB_LOW
                                 |=> reg_rdata[5:0] == 6'h00)
    else $error("low result register reserved bits set");

endmodule

// [tb/rscr_host.sv]
// Host model: drives the register port of the radio register bank.
// Assumes the bench shares clk; requests change at the falling edge.
`timescale 1ns/1ps
module rscr_host
  import rscr_pkg::*;
(
  input  wire logic        clk,
  output logic      [10:0] reg_addr,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [7:0]  reg_wdata,
  input  wire logic [7:0]  reg_rdata
);
  initial
  begin
    reg_addr  = 11'h7ff;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end

  // Idle lines show the inverse, so a stale address never reads as valid
  // Callers keep reserved converter bits as required
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
  begin
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  end
  endtask

  task automatic rd(input logic [10:0] a, output logic [7:0] d);
  begin
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata;
  end
  endtask
endmodule

// [tb/rscr_regs_test.sv]
// Self-checking bench for the radio register bank.
// Assumes the host model owns the register port; events are driven here.
`timescale 1ns/1ps
module rscr_regs_test
  import rscr_pkg::*;
;
  logic clk = 0, srst = 1, lp_mode = 0, cip_ld = 0, pkt_mode = 0, sdone = 0, fdone = 0;
  logic ramp = 0, cvalid = 0;
  logic [7:0] ev_r = 0, ev_s = 0, level = 0, thr = 8'h50, csample = 0, rdata, rv;
  logic [15:0] limit = 16'h0003;
  logic [5:0] fword = 6'h2a;
  logic [10:0] reg_addr;
  logic reg_wr, reg_rd, syn_en, flt_en, ref_en, tick;
  logic [7:0] wdata, loop_s;
  logic [5:0] cal_word;
  logic [1:0] chsel, refsel;
  logic [15:0] wcount;
  int err_count = 0, total_checks = 0, cyc = 0, n, i;
  logic [10:0] ra [10] = '{11'h32f, 11'h336, 11'h337, 11'h338, 11'h339, 11'h345, 11'h346,
                           11'h359, 11'h35a, 11'h300};
  logic [7:0]  rr [10] = '{8'h28, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1f, 8'h00};
  logic [7:0]  wd [10] = '{8'hff, 8'hff, 8'h03, 8'h7f, 8'h0f, 8'h6f, 8'hff, 8'hff, 8'hff, 8'hff};
  logic [10:0] wa [10] = '{11'h32f, 11'h337, 11'h338, 11'h346, 11'h359, 11'h35a, 11'h339,
                           11'h345, 11'h300, 11'h327};
  logic [7:0]  we [10] = '{8'hff, 8'hd3, 8'h03, 8'h7f, 8'h0f, 8'h6f, 8'h00, 8'h00, 8'h00, 8'h00};

  always #4 clk = ~clk;

  rscr_host rscr_host_i (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
                         .reg_wdata(wdata), .reg_rdata(rdata));

  rscr_regs rscr_regs_i (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(wdata), .reg_rdata(rdata), .wake_event(ev_r[7]),
    .wake_count_limit(limit), .lowpower_mode(lp_mode), .signal_valid(ev_r[6]),
    .signal_level(level), .lowpower_signal_threshold(thr), .cipher_loaded(cip_ld),
    .cipher_done(ev_r[5]), .packet_mode(pkt_mode), .tx_done(ev_r[4]), .addr_match(ev_r[3]),
    .crc_good(ev_r[2]), .sync_found(ev_r[1]), .preamble_found(ev_r[0]),
    .supply_low(ev_s[7]), .cmd_ready(ev_s[6]), .wake_timer_expired(ev_s[4]),
    .port_ready(ev_s[1]), .cmd_done(ev_s[0]), .synth_calibrate_done(sdone),
    .filter_calibrate_done(fdone), .power_ramp_done(ramp), .filter_cal_word_in(fword),
    .conv_valid(cvalid), .conv_sample(csample), .synth_calibrate_enable(syn_en),
    .filter_calibrate_enable(flt_en), .filter_cal_word(cal_word),
    .converter_channel_select(chsel), .converter_reference_select(refsel),
    .converter_reference_enable(ref_en), .gain_tick(tick), .gain_loop_sample(loop_s),
    .wake_counter(wcount));

  // ----------------------------------------------------------------
  // Check helpers
  // ----------------------------------------------------------------
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
  begin
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask

  task automatic chk(input logic [10:0] a, input logic [7:0] exp);
  begin
    rscr_host_i.rd(a, rv);
    cmp(rv, exp);
  end
  endtask

  // Events are one-cycle pulses, driven away from the sampling edge
  task automatic pulse(input logic [7:0] r, input logic [7:0] s);
  begin
    @(negedge clk);
    ev_r = r;
    ev_s = s;
    @(negedge clk);
    ev_r = 8'h00;
    ev_s = 8'h00;
  end
  endtask

  task automatic ticks(input int c, output int k);
  begin
    k = 0;
    repeat (c)
    begin
      @(posedge clk);
      #1;
      if (tick === 1'b1)
        k++;
    end
  end
  endtask

  task automatic finish_test;
  begin
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask

  // Ceiling well above the roughly 8100 cycles the sequence needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    for (i = 0; i < 10; i++) chk(ra[i], rr[i]);
    cmp({7'h0, ref_en}, 8'h01);
    for (i = 0; i < 10; i++)
    begin
      rscr_host_i.wr(wa[i], wd[i]);
      chk(wa[i], we[i]);
    end
    cmp({2'b0, syn_en, flt_en, chsel, refsel}, 8'h3f);
    cmp({1'b0, ref_en, cal_word}, 8'h3f);
    foreach (wa[j]) if (j < 5) rscr_host_i.wr(wa[j], 8'h00);
    rscr_host_i.wr(11'h35a, 8'h1f);
    pkt_mode = 1'b1;
    cip_ld = 1'b1;
    lp_mode = 1'b1;
    level = 8'h51;
    for (i = 0; i < 7; i++)
    begin
      pulse(8'h01 << i, 8'h00);
      chk(11'h336, 8'h01 << i);
      chk(11'h336, 8'h01 << i);
      rscr_host_i.wr(11'h336, 8'h00);
      chk(11'h336, 8'h00);
    end
    level = 8'h50;
    pulse(8'h40, 8'h00);
    chk(11'h336, 8'h00);
    pulse(8'h80, 8'h00);
    pulse(8'h80, 8'h00);
    chk(11'h336, 8'h00);
    pulse(8'h80, 8'h00);
    chk(11'h336, 8'h80);
    cmp(wcount[7:0], 8'h03);
    rscr_host_i.wr(11'h336, 8'h00);
    pkt_mode = 1'b0;
    cip_ld = 1'b0;
    lp_mode = 1'b0;
    level = 8'h51;
    pulse(8'h7c, 8'h00);
    chk(11'h336, 8'h00);
    for (i = 0; i < 8; i++) if (EV_SYSTEM_USE[i])
    begin
      pulse(8'h00, 8'h01 << i);
      chk(11'h337, 8'h01 << i);
      rscr_host_i.wr(11'h337, 8'h00);
    end
    rscr_host_i.wr(11'h338, 8'h01);
    sdone = 1'b1;
    ramp = 1'b1;
    @(negedge clk);
    fdone = 1'b1;
    chk(11'h339, 8'h07);
    chk(11'h345, 8'h2a);
    cmp({2'b0, cal_word}, 8'h2a);
    rscr_host_i.wr(11'h346, 8'h2b);
    cmp({2'b0, cal_word}, 8'h15);
    rscr_host_i.wr(11'h338, 8'h00);
    chk(11'h339, 8'h06);
    rscr_host_i.wr(11'h32f, 8'h01);
    ticks(1000, n);
    cmp((n >= 12 && n <= 14) ? 8'h01 : 8'h00, 8'h01);
    rscr_host_i.wr(11'h32f, 8'h00);
    repeat (5) @(posedge clk);
    ticks(300, n);
    cmp(n[7:0], 8'h00);
    @(negedge clk);
    cvalid = 1'b1;
    csample = 8'hb6;
    @(negedge clk);
    cvalid = 1'b0;
    chk(11'h327, 8'h2d);
    chk(11'h328, 8'h80);
    cmp(loop_s, 8'hb6);
    rscr_host_i.wr(11'h35a, 8'h3f);
    chk(11'h327, 8'h2d);
    chk(11'h327, 8'h0b);
    for (i = 1; i < 4; i++)
    begin
      rscr_host_i.wr(11'h35a, {1'b0, i[1:0], 5'h1f});
      chk(11'h35a, {1'b0, i[1:0], 5'h1f});
    end
    csample = 8'h80;
    repeat (40)
    begin
      @(negedge clk);
      cvalid = ~cvalid;
    end
    cmp((loop_s >= 8'h7c && loop_s <= 8'h84) ? 8'h01 : 8'h00, 8'h01);
    chk(11'h327, 8'h0b);
    sdone = 1'b0;
    ramp = 1'b0;
    fdone = 1'b0;
    srst = 1'b1;
    repeat (10) @(negedge clk);
    srst = 1'b0;
    for (i = 0; i < 10; i++) chk(ra[i], rr[i]);
    ticks(6500, n);
    cmp(n[7:0], 8'h02);
    finish_test();
  end
endmodule
